// *** hw/dsadc_pkg.sv ***
// Constants, register map and enumerations for the delta-sigma ADC sequencer.
// Assumes a single 50 MHz clock and an AXI4-Lite master on the register side.
// Operation
// RL1 - Each result depends on the four most recent modulator samples.
// RL2 - After an input change, results are invalid until the fourth sample after it.
// RL3 - Four modes: single, multi, continuous, multi turbo.
// RL4 - Start by control start bit or external start input.
// RL5 - Completion sets status bit and raises done output.
// RL6 - Done stays high until result is read, then drops.
// RL7 - Single mode idles in standby without sampling until a start.
// RL8 - Single trigger runs four conversions; first three only prime.
// RL9 - Single result valid after fourth conversion, done raised then.
// RL10 - After transfer, single mode returns to standby until next start.
// RL11 - Host may poll status or use done for interrupt or DMA.
// RL12 - Configuration picks 12-bit slower rate or 8-bit faster rate.
// RL13 - Decimator turns serial modulator bit stream into parallel words.
// RL14 - Continuous: first result after three priming conversions, then every conversion.
// RL15 - Multi mode re-primes between samples and restarts automatically.
// RL16 - External start input is optional in continuous mode.
// RL17 - A start during a running sequence is ignored.
package dsadc_pkg;
  localparam logic [3:0] DSADC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] DSADC_ADDR_STAT = 4'h4;
  localparam logic [3:0] DSADC_ADDR_MASK = 4'h8;
  localparam logic [3:0] DSADC_ADDR_RES = 4'hc;
  localparam int DSADC_CTRL_START = 0;
  localparam int DSADC_CTRL_MODE_LO = 1;
  localparam int DSADC_CTRL_RES8 = 3;
  localparam int DSADC_CTRL_CHAN_LO = 4;
  localparam int DSADC_CHAN_W = 3;
  localparam int DSADC_STAT_DONE = 0;
  localparam int DSADC_STAT_BUSY = 1;
  localparam int DSADC_STAT_VALID = 2;
  localparam logic [1:0] DSADC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSADC_RESP_SLVERR = 2'h2;
  localparam int DSADC_PRIME_CONV = 3;
  localparam int DSADC_PIPE_DEPTH = 4;
  // Modulator bits per conversion; finer resolution needs a longer conversion
  localparam int DSADC_OSR_12 = 4096;
  localparam int DSADC_OSR_8 = 256;
  typedef enum logic [1:0] {
    DSADC_M_SINGLE,
    DSADC_M_MULTI,
    DSADC_M_CONT,
    DSADC_M_TURBO
  } dsadc_mode_t;
  typedef enum {
    DSADC_S_STANDBY,
    DSADC_S_RUN,
    DSADC_S_HOLD
  } dsadc_state_t;
endpackage

// *** hw/dsadc_top.sv ***
// Delta-sigma ADC sequencer: modulator bit-stream decimator, mode sequencer,
// AXI4-Lite register slave and level interrupt.
// Assumes all inputs synchronous to CLOCK; MOD_BIT is one modulator bit per cycle.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module dsadc_top
  import dsadc_pkg::*;
#(
  parameter int OSR_12 = DSADC_OSR_12,
  parameter int OSR_8 = DSADC_OSR_8
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic MOD_BIT,
  input wire logic SOC,
  output logic EOC,
  output logic IRQ,
  output logic [DSADC_CHAN_W-1:0] CHAN_SEL,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  initial begin
    if (OSR_8 < 16 || OSR_12 <= OSR_8 || OSR_12 > 65536) begin
      $error("dsadc_top: unsupported over-sampling ratio");
    end
  end
  // Bus state
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt, awready_r, wready_r, arready_r;
  logic [3:0] awaddr_r, awaddr_nxt, wstrb_r, wstrb_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt, bresp_r, bresp_nxt;
  // Control and status
  dsadc_mode_t mode_r, mode_nxt;
  logic res8_r, res8_nxt, start_sw, chan_chg, res_read;
  logic [DSADC_CHAN_W-1:0] chan_r, chan_nxt;
  logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
  // Sequencer and decimator
  dsadc_state_t st_r, st_nxt;
  logic [16:0] bitcnt_r, bitcnt_nxt, acc_r, acc_nxt, osr;
  logic [16:0] conv_r [DSADC_PIPE_DEPTH], conv_nxt [DSADC_PIPE_DEPTH];
  logic [2:0] fill_r, fill_nxt;
  logic [11:0] result_r, result_nxt;
  logic valid_r, valid_nxt, eoc_r, eoc_nxt, irq_r, irq_nxt, conv_end, fire, done_evt;
  logic [18:0] sum4;
  wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign start_sw = wr_fire && awaddr_r == DSADC_ADDR_CTRL && wstrb_r[0]
                    && wdata_r[DSADC_CTRL_START];
  assign chan_chg = wr_fire && awaddr_r == DSADC_ADDR_CTRL && wstrb_r[0]
                    && wdata_r[DSADC_CTRL_CHAN_LO +: DSADC_CHAN_W] != chan_r;
  assign res_read = S_AXI_ARVALID && !rvalid_r && S_AXI_ARADDR == DSADC_ADDR_RES;
  assign osr = res8_r ? 17'(OSR_8) : 17'(OSR_12);
  assign conv_end = st_r == DSADC_S_RUN && bitcnt_r == osr - 17'h00001;
  // AXI4-Lite slave: address and data taken in either order, response after both
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (S_AXI_AWVALID && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_got_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (awaddr_r[1:0] == 2'h0) ? DSADC_RESP_OKAY : DSADC_RESP_SLVERR;
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = DSADC_RESP_OKAY;
      case (S_AXI_ARADDR)
        DSADC_ADDR_CTRL: rdata_nxt = {25'h0, chan_r, res8_r, mode_r, 1'b0};
        DSADC_ADDR_STAT: rdata_nxt = {29'h0, stat_r};
        DSADC_ADDR_MASK: rdata_nxt = {29'h0, mask_r};
        DSADC_ADDR_RES: rdata_nxt = {20'h0, result_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = DSADC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end
  // Control registers, sticky status and interrupt
  always_comb begin
    mode_nxt = mode_r;
    res8_nxt = res8_r;
    chan_nxt = chan_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_fire && awaddr_r == DSADC_ADDR_CTRL && wstrb_r[0]) begin
      mode_nxt = dsadc_mode_t'(wdata_r[DSADC_CTRL_MODE_LO +: 2]); // see RL3
      res8_nxt = wdata_r[DSADC_CTRL_RES8]; // see RL12
      chan_nxt = wdata_r[DSADC_CTRL_CHAN_LO +: DSADC_CHAN_W];
    end
    if (wr_fire && awaddr_r == DSADC_ADDR_MASK && wstrb_r[0]) begin
      mask_nxt = wdata_r[2:0];
    end
    if (wr_fire && awaddr_r == DSADC_ADDR_STAT && wstrb_r[0]) begin
      stat_nxt = stat_r & ~wdata_r[2:0];
    end
    if (chan_chg) stat_nxt[DSADC_STAT_VALID] = 1'b0; // see RL2
    // Set wins over a clear in the same cycle
    if (done_evt) begin
      stat_nxt[DSADC_STAT_DONE] = 1'b1; // see RL5
    end
    // Busy is live state, so a one written to it has no lasting effect
    stat_nxt[DSADC_STAT_BUSY] = st_nxt != DSADC_S_STANDBY;
    if (done_evt && valid_nxt) begin
      stat_nxt[DSADC_STAT_VALID] = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end
  // Sequencer: standby, run conversions, hold a single result until read
  always_comb begin
    st_nxt = st_r;
    bitcnt_nxt = bitcnt_r;
    acc_nxt = acc_r;
    conv_nxt = conv_r;
    fill_nxt = fill_r;
    result_nxt = result_r;
    valid_nxt = valid_r;
    eoc_nxt = eoc_r;
    done_evt = 1'b0;
    fire = 1'b0;
    sum4 = 19'h0;
    for (int i = 0; i < DSADC_PIPE_DEPTH; i++) begin
      sum4 = sum4 + {2'h0, conv_r[i]};
    end
    if (res_read) begin
      eoc_nxt = 1'b0; // see RL6
    end
    case (st_r)
      DSADC_S_STANDBY: begin
        if (start_sw || SOC) begin // see RL4
          st_nxt = DSADC_S_RUN; // see RL7
          fire = 1'b1;
          bitcnt_nxt = 17'h0;
          acc_nxt = 17'h0;
          fill_nxt = 3'h0;
        end
      end
      DSADC_S_RUN: begin
        // Further starts are ignored here and the count runs on, see RL17
        acc_nxt = acc_r + {16'h0, MOD_BIT}; // see RL13
        bitcnt_nxt = bitcnt_r + 17'h00001;
        if (conv_end) begin
          bitcnt_nxt = 17'h0;
          acc_nxt = 17'h0;
          conv_nxt[0] = acc_r + {16'h0, MOD_BIT};
          for (int i = 1; i < DSADC_PIPE_DEPTH; i++) begin
            conv_nxt[i] = conv_r[i-1]; // see RL1
          end
          if (fill_r < 3'(DSADC_PRIME_CONV)) begin
            fill_nxt = fill_r + 3'h1; // see RL8
          end else begin
            // Sum of four conversions scaled down to the result width
            sum4 = sum4 - {2'h0, conv_r[DSADC_PIPE_DEPTH-1]} + {2'h0, conv_nxt[0]};
            result_nxt = res8_r ? {4'h0, sum4[9:2]} : sum4[14:3];
            valid_nxt = 1'b1;
            done_evt = 1'b1;
            eoc_nxt = 1'b1; // see RL9
            case (mode_r)
              DSADC_M_SINGLE: st_nxt = DSADC_S_HOLD;
              DSADC_M_CONT: fill_nxt = fill_r; // see RL14
              DSADC_M_MULTI, DSADC_M_TURBO: fill_nxt = 3'h0; // see RL15
              default: st_nxt = DSADC_S_HOLD;
            endcase
          end
        end
      end
      DSADC_S_HOLD: begin
        if (res_read) begin
          st_nxt = DSADC_S_STANDBY; // see RL10
        end
      end
      default: st_nxt = DSADC_S_STANDBY;
    endcase
    // Input change invalidates the pipeline; placed last so it wins at a conversion end
    if (chan_chg) begin
      fill_nxt = 3'h0; // see RL2
      valid_nxt = 1'b0;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= DSADC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= DSADC_RESP_OKAY;
      {awready_r, wready_r, arready_r} <= 3'h7;
      mode_r <= DSADC_M_SINGLE;
      res8_r <= 1'b0;
      chan_r <= '0;
      mask_r <= 3'h0;
      stat_r <= 3'h0;
      irq_r <= 1'b0;
      st_r <= DSADC_S_STANDBY;
      bitcnt_r <= 17'h0;
      acc_r <= 17'h0;
      conv_r <= '{default: 17'h0};
      fill_r <= 3'h0;
      result_r <= 12'h0;
      valid_r <= 1'b0;
      eoc_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      {awready_r, wready_r, arready_r} <= {!aw_got_nxt, !w_got_nxt, !rvalid_nxt};
      mode_r <= mode_nxt;
      res8_r <= res8_nxt;
      chan_r <= chan_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      st_r <= st_nxt;
      bitcnt_r <= bitcnt_nxt;
      acc_r <= acc_nxt;
      conv_r <= conv_nxt;
      fill_r <= fill_nxt;
      result_r <= result_nxt;
      valid_r <= valid_nxt;
      eoc_r <= eoc_nxt;
    end
  end
  assign EOC = eoc_r;
  assign IRQ = irq_r;
  assign CHAN_SEL = chan_r;
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // Assertions
  property p_done_sets_eoc;
    @(posedge CLOCK) disable iff (!RST_N) done_evt |=> EOC && stat_r[DSADC_STAT_DONE];
  endproperty
  a_done_sets_eoc: assert property (p_done_sets_eoc) else $error("EOC not raised"); // see RL5
  property p_eoc_read;
    @(posedge CLOCK) disable iff (!RST_N) res_read && !done_evt |=> !EOC;
  endproperty
  a_eoc_read: assert property (p_eoc_read) else $error("EOC stayed after read"); // see RL6
  property p_eoc_hold;
    @(posedge CLOCK) disable iff (!RST_N) EOC && !res_read |=> EOC;
  endproperty
  a_eoc_hold: assert property (p_eoc_hold) else $error("EOC dropped early"); // see RL6
  property p_standby_idle;
    @(posedge CLOCK) disable iff (!RST_N)
      st_r == DSADC_S_STANDBY && !SOC && !start_sw |=> st_r == DSADC_S_STANDBY;
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("Left standby"); // see RL7
  property p_start;
    @(posedge CLOCK) disable iff (!RST_N)
      st_r == DSADC_S_STANDBY && (SOC || start_sw) |=> st_r == DSADC_S_RUN && bitcnt_r == 0;
  endproperty
  a_start: assert property (p_start) else $error("Start not taken"); // see RL4
  property p_prime;
    @(posedge CLOCK) disable iff (!RST_N) done_evt |-> fill_r == 3'(DSADC_PRIME_CONV);
  endproperty
  a_prime: assert property (p_prime) else $error("Result before priming"); // see RL8
  property p_single_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      done_evt && mode_r == DSADC_M_SINGLE |=> st_r == DSADC_S_HOLD;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("Single not held"); // see RL9
  property p_back_standby;
    @(posedge CLOCK) disable iff (!RST_N)
      st_r == DSADC_S_HOLD && res_read |=> st_r == DSADC_S_STANDBY;
  endproperty
  a_back_standby: assert property (p_back_standby) else $error("No standby"); // see RL10
  property p_ignore;
    @(posedge CLOCK) disable iff (!RST_N)
      st_r == DSADC_S_RUN && !conv_end && SOC |=> bitcnt_r == $past(bitcnt_r) + 1;
  endproperty
  a_ignore: assert property (p_ignore) else $error("Start restarted run"); // see RL17
  property p_irq;
    @(posedge CLOCK) disable iff (!RST_N) IRQ == |(stat_r & mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("IRQ mismatch");
  property p_busy;
    @(posedge CLOCK) disable iff (!RST_N) fire |=> stat_r[DSADC_STAT_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("Busy not shown"); // see RL4
  c_single: cover property (@(posedge CLOCK) disable iff (!RST_N)
    done_evt && mode_r == DSADC_M_SINGLE);
  c_cont: cover property (@(posedge CLOCK) disable iff (!RST_N)
    done_evt && mode_r == DSADC_M_CONT);
  c_multi: cover property (@(posedge CLOCK) disable iff (!RST_N)
    done_evt && mode_r == DSADC_M_MULTI);
endmodule // dsadc_top

// *** bench/dsadc_modsrc.sv ***
// Modulator model: one bit per clock, a steady stream of ones or zeros.
// Assumes the bench changes the level only between conversions.
`timescale 1ns/1ns
module dsadc_modsrc (
  input wire logic clk,
  input wire logic lvl,
  output logic mod_bit
);
  // Registered so the stream moves only after an edge, as a real modulator does
  always @(posedge clk) begin
    mod_bit <= lvl;
  end
endmodule // dsadc_modsrc

// *** bench/dsadc_test.sv ***
// Bench for the delta-sigma ADC sequencer: AXI4-Lite register tasks and
// timed conversion checks. Assumes short conversion counts set below.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dsadc_test;
  import dsadc_pkg::*;
  localparam int OSR12 = 64;
  localparam int OSR8 = 16;
  localparam int LIMIT = 20000;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic soc = 1'h0;
  logic lvl = 1'h0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awv = 1'h0;
  logic wv = 1'h0;
  logic arv = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic mod_bit, eoc, irq, awr, wr_rdy, bv, arr, rv;
  logic [2:0] chan;
  logic [31:0] rdata, d;
  logic [1:0] bresp, rresp, rs;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n, te, tp, t0;

  dsadc_modsrc mod_u (.clk(clk), .lvl(lvl), .mod_bit(mod_bit));
  // Response ready lines stay high: the bench always takes an answer at once
  dsadc_top #(.OSR_12(OSR12), .OSR_8(OSR8)) dut_u (
    .CLOCK(clk), .RST_N(rst_n), .MOD_BIT(mod_bit), .SOC(soc), .EOC(eoc), .IRQ(irq),
    .CHAN_SEL(chan), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'h1), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(1'h1));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, which shows what the next rise samples
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ha, hw, h;
    awaddr <= a;
    wdata <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr_rdy;
      h = bv;
      rs = bresp;
      @(posedge clk);
      if (ha) awv <= 1'h0;
      if (hw) wv <= 1'h0;
    end while (!h);
  endtask

  task automatic rd(input logic [3:0] a);
    logic ha, h;
    araddr <= a;
    arv <= 1'h1;
    do begin
      @(negedge clk);
      ha = arv && arr;
      h = rv;
      d = rdata;
      rs = rresp;
      @(posedge clk);
      if (ha) arv <= 1'h0;
    end while (!h);
  endtask

  task automatic wait_eoc(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (eoc !== 1'h1 && c < 2000);
    te = cyc;
    @(posedge clk);
  endtask

  task automatic reset_dut();
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
  endtask

  initial begin
    reset_dut();
    rd(DSADC_ADDR_CTRL);
    `CHK(d, 32'h0)
    rd(4'h2);
    `CHK({rs, d}, {DSADC_RESP_SLVERR, 32'h0})
    wr(4'h6, 32'h1);
    `CHK(rs, DSADC_RESP_SLVERR)
    repeat (200) @(posedge clk);
    rd(DSADC_ADDR_STAT);
    `CHK({eoc, irq, d[2:0]}, 5'h0)
    // Single, 8-bit, started by the control bit
    lvl <= 1'h1;
    wr(DSADC_ADDR_MASK, 32'h1);
    wr(DSADC_ADDR_CTRL, 32'h9);
    wait_eoc(n);
    `CHK(n inside {[4*OSR8-6:4*OSR8+8]}, 1'h1)
    rd(DSADC_ADDR_STAT);
    `CHK({d[DSADC_STAT_VALID], d[DSADC_STAT_DONE], irq}, 3'h7)
    wr(DSADC_ADDR_MASK, 32'h0);
    `CHK(irq, 1'h0)
    wr(DSADC_ADDR_MASK, 32'h1);
    `CHK({eoc, irq}, 2'h3)
    rd(DSADC_ADDR_RES);
    `CHK(d != 32'h0, 1'h1)
    `CHK(d[31:8], 24'h0)
    @(negedge clk);
    `CHK(eoc, 1'h0)
    @(posedge clk);
    wr(DSADC_ADDR_STAT, 32'h5);
    repeat (200) @(posedge clk);
    rd(DSADC_ADDR_STAT);
    `CHK({eoc, irq, d[2:0]}, 5'h0)
    // Single, 12-bit, external start; a second start mid-run must not restart
    lvl <= 1'h0;
    wr(DSADC_ADDR_CTRL, 32'h0);
    soc <= 1'h1;
    @(negedge clk);
    t0 = cyc;
    @(posedge clk);
    soc <= 1'h0;
    repeat (2 * OSR12) @(posedge clk);
    soc <= 1'h1;
    @(posedge clk);
    soc <= 1'h0;
    wr(DSADC_ADDR_CTRL, 32'h1);
    wait_eoc(n);
    `CHK((te - t0) inside {[4*OSR12-4:4*OSR12+8]}, 1'h1)
    rd(DSADC_ADDR_RES);
    `CHK(d, 32'h0)
    // Continuous, 8-bit: priming once, then one result per conversion
    wr(DSADC_ADDR_CTRL, 32'hd);
    wait_eoc(n);
    `CHK(n inside {[4*OSR8-6:4*OSR8+8]}, 1'h1)
    tp = te;
    rd(DSADC_ADDR_RES);
    wait_eoc(n);
    `CHK((te - tp) inside {[OSR8-4:OSR8+8]}, 1'h1)
    rd(DSADC_ADDR_RES);
    wr(DSADC_ADDR_CTRL, 32'h5c);
    rd(DSADC_ADDR_STAT);
    `CHK({chan, d[DSADC_STAT_VALID]}, 4'ha)
    wait_eoc(n);
    `CHK(n >= 3 * OSR8 - 4, 1'h1)
    // Multi and turbo: full re-prime between results
    for (int m = 1; m < 4; m += 2) begin
      reset_dut();
      wr(DSADC_ADDR_CTRL, 32'h9 | 32'(m << 1));
      wait_eoc(n);
      tp = te;
      rd(DSADC_ADDR_RES);
      wait_eoc(n);
      `CHK((te - tp) inside {[4*OSR8-4:4*OSR8+8]}, 1'h1)
    end
    summarize();
  end
endmodule // dsadc_test
